//--- hdl/hub_power_params.svh
// Constants for the downstream port power and connectivity block.
// Assumes inclusion by bare name from the design files.
`ifndef HUB_POWER_PARAMS_SVH
`define HUB_POWER_PARAMS_SVH

// Register offsets
`define REG_REMOVABLE   8'h07
`define REG_PORT_USED   8'h08
`define REG_STAT_CMD    8'hf8

// Status and command fields
`define STAT_HOLD_BIT   0
`define STAT_GANG_BIT   1
`define STAT_OC_LSB     4
`define STAT_CMD_RST    8'h00
`define STAT_WR_MASK    8'h01

// Reset values and strap timing
`define CFG_ZERO        4'h0
`define CFG_ONE_PORT    4'h1
`define OC_IDLE         4'hf
`define STRAP_CAP_DLY   2'h3
`define CNT_ZERO        2'h0
`define CNT_ONE         2'h1
`define PORT_COUNT_RST  3'h1
`define RDATA_ZERO      8'h00

`endif

//--- hdl/hub_power_pkg.sv
// Types for the downstream port power and connectivity block.
// Assumes nothing of its surroundings.
package hub_power_pkg;

  typedef enum logic [1:0] {
    CFG_SETTLE  = 2'b00,
    CFG_CAPTURE = 2'b01,
    CFG_RUN     = 2'b10
  } cfg_state_t;

endpackage

//--- hdl/reset_sync.sv
// Reset synchroniser: asynchronous entry, release on the clock.
// Assumes an active-low reset pin from outside the clock domain.
`timescale 1ns/100ps

module reset_sync (
  input  wire logic clk_sys_i,
  input  wire logic global_reset_n_i,
  output logic      rst_o
);

  logic stage1_reg;
  logic stage2_reg;

  always_ff @(posedge clk_sys_i or negedge global_reset_n_i) begin
    if (!global_reset_n_i) begin
      stage1_reg <= 1'b1;
      stage2_reg <= 1'b1;
    end else begin
      stage1_reg <= 1'b0;
      stage2_reg <= stage1_reg;
    end
  end

  assign rst_o = stage2_reg;

endmodule // reset_sync

//--- hdl/port_oc_latch.sv
// Over-current fault latch for one downstream port.
// Assumes fault and clear inputs from logic on the same clock.
`timescale 1ns/100ps

module port_oc_latch (
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  input  wire logic oc_i,
  input  wire logic clr_i,
  output logic      fault_o
);

  logic fault_reg;
  logic fault_next;

  // Set wins over clear
  always_comb begin
    fault_next = oc_i | (fault_reg & ~clr_i);
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      fault_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
    end
  end

  assign fault_o = fault_reg;

endmodule // port_oc_latch

//--- hdl/hub_port_power_control.sv
// Downstream port power switching, over-current shutdown, speed policy
// and port configuration of a four-port hub.
// Assumes straps and over-current pins are asynchronous; host requests,
// upstream speed flags and the register port run on clk_sys_i.
//
// Function
// - Upstream SuperSpeed and high-speed may coexist.
// - No upstream SuperSpeed disables downstream SuperSpeed.
// - Full/low-speed upstream also disables downstream high-speed.
// - Report one to four ports by configuration.
// - Ports configurable disabled or permanently attached.
// - Per-port mode follows host request per port.
// - Per-port over-current removes only that port.
// - Ganged mode powers all when any needs.
// - Ganged power stays until all permit removal.
// - Ganged over-current switches all ports off.
// - EEPROM loads never alter status/command register.
// - Global reset restores all register defaults.
// - Device does nothing while reset held.
// - Ganged mode: port 0 output powers all.
`timescale 1ns/100ps
`include "hub_power_params.svh"

module hub_port_power_control
  import hub_power_pkg::*;
#(
  parameter int NUM_PORTS = 4
) (
  input  wire logic                 clk_sys_i,
  input  wire logic                 global_reset_n_i,
  input  wire logic                 gang_mode_strap_i,
  input  wire logic [NUM_PORTS-1:0] strap_port_used_i,
  input  wire logic [NUM_PORTS-1:0] strap_removable_i,
  input  wire logic [NUM_PORTS-1:0] port_overcurrent_n_i,
  input  wire logic [NUM_PORTS-1:0] port_power_req_i,
  input  wire logic                 upstream_ss_i,
  input  wire logic                 upstream_hs_i,
  input  wire logic                 reg_wr_i,
  input  wire logic                 reg_src_eeprom_i,
  input  wire logic [7:0]           reg_addr_i,
  input  wire logic [7:0]           reg_wdata_i,
  output logic [7:0]                reg_rdata_o,
  output logic [NUM_PORTS-1:0]      port_power_on_n_o,
  output logic [NUM_PORTS-1:0]      ds_ss_en_o,
  output logic [NUM_PORTS-1:0]      ds_hs_en_o,
  output logic [NUM_PORTS-1:0]      port_fixed_o,
  output logic [2:0]                port_count_o
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [NUM_PORTS-1:0] eff_used(input logic [NUM_PORTS-1:0] u);
    eff_used = (u == '0) ? NUM_PORTS'(`CFG_ONE_PORT) : u;
  endfunction

  function automatic logic [2:0] pop_count(input logic [NUM_PORTS-1:0] u);
    pop_count = 3'h0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      pop_count = pop_count + {2'h0, u[i]};
    end
  endfunction

  // ****************************************************************
  // Reset and pin synchronisers
  // ****************************************************************
  logic                 rst;
  logic                 gang_s1_reg;
  logic                 gang_s2_reg;
  logic [NUM_PORTS-1:0] used_s1_reg;
  logic [NUM_PORTS-1:0] used_s2_reg;
  logic [NUM_PORTS-1:0] rem_s1_reg;
  logic [NUM_PORTS-1:0] rem_s2_reg;
  logic [NUM_PORTS-1:0] oc_s1_reg;
  logic [NUM_PORTS-1:0] oc_s2_reg;

  reset_sync u_reset_sync (
    .clk_sys_i        (clk_sys_i),
    .global_reset_n_i (global_reset_n_i),
    .rst_o            (rst)
  );

  always_ff @(posedge clk_sys_i or posedge rst) begin
    if (rst) begin
      gang_s1_reg <= 1'b0;
      gang_s2_reg <= 1'b0;
      used_s1_reg <= NUM_PORTS'(`CFG_ZERO);
      used_s2_reg <= NUM_PORTS'(`CFG_ZERO);
      rem_s1_reg  <= NUM_PORTS'(`CFG_ZERO);
      rem_s2_reg  <= NUM_PORTS'(`CFG_ZERO);
      oc_s1_reg   <= NUM_PORTS'(`OC_IDLE);
      oc_s2_reg   <= NUM_PORTS'(`OC_IDLE);
    end else begin
      gang_s1_reg <= gang_mode_strap_i;
      gang_s2_reg <= gang_s1_reg;
      used_s1_reg <= strap_port_used_i;
      used_s2_reg <= used_s1_reg;
      rem_s1_reg  <= strap_removable_i;
      rem_s2_reg  <= rem_s1_reg;
      oc_s1_reg   <= port_overcurrent_n_i;
      oc_s2_reg   <= oc_s1_reg;
    end
  end

  logic [NUM_PORTS-1:0] oc_det;

  assign oc_det = ~oc_s2_reg;

  // ****************************************************************
  // Configuration and registers
  // ****************************************************************
  cfg_state_t           cfg_state_reg;
  cfg_state_t           cfg_state_next;
  logic [1:0]           cap_cnt_reg;
  logic [1:0]           cap_cnt_next;
  logic                 gang_mode_reg;
  logic                 gang_mode_next;
  logic [NUM_PORTS-1:0] used_reg;
  logic [NUM_PORTS-1:0] used_next;
  logic [NUM_PORTS-1:0] removable_reg;
  logic [NUM_PORTS-1:0] removable_next;
  logic [7:0]           stat_cmd_reg;
  logic [7:0]           stat_cmd_next;
  logic [7:0]           rdata_reg;
  logic [7:0]           rdata_next;
  logic [NUM_PORTS-1:0] fault;
  logic                 run;

  assign run = (cfg_state_reg == CFG_RUN);

  always_comb begin
    cfg_state_next = cfg_state_reg;
    cap_cnt_next   = cap_cnt_reg;
    gang_mode_next = gang_mode_reg;
    used_next      = used_reg;
    removable_next = removable_reg;
    stat_cmd_next  = stat_cmd_reg;
    unique case (cfg_state_reg)
      CFG_SETTLE: begin
        cap_cnt_next = cap_cnt_reg + `CNT_ONE;
        if (cap_cnt_reg == `STRAP_CAP_DLY) begin
          cfg_state_next = CFG_CAPTURE;
        end
      end
      CFG_CAPTURE: begin
        gang_mode_next = gang_s2_reg;
        used_next      = used_s2_reg;
        removable_next = rem_s2_reg;
        cfg_state_next = CFG_RUN;
      end
      CFG_RUN: begin
        if (reg_wr_i) begin
          if (reg_addr_i == `REG_PORT_USED) begin
            used_next = reg_wdata_i[NUM_PORTS-1:0];
          end
          if (reg_addr_i == `REG_REMOVABLE) begin
            removable_next = reg_wdata_i[NUM_PORTS-1:0];
          end
          if ((reg_addr_i == `REG_STAT_CMD) && !reg_src_eeprom_i) begin
            stat_cmd_next = reg_wdata_i & `STAT_WR_MASK;
          end
        end
      end
      default: begin
        cfg_state_next = CFG_SETTLE;
      end
    endcase
  end

  always_comb begin
    rdata_next = `RDATA_ZERO;
    if (reg_addr_i == `REG_PORT_USED) begin
      rdata_next[NUM_PORTS-1:0] = used_reg;
    end else if (reg_addr_i == `REG_REMOVABLE) begin
      rdata_next[NUM_PORTS-1:0] = removable_reg;
    end else if (reg_addr_i == `REG_STAT_CMD) begin
      rdata_next = stat_cmd_reg;
      rdata_next[`STAT_GANG_BIT] = gang_mode_reg;
      rdata_next[`STAT_OC_LSB +: NUM_PORTS] = fault;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst) begin
    if (rst) begin
      cfg_state_reg <= CFG_SETTLE;
      cap_cnt_reg   <= `CNT_ZERO;
      gang_mode_reg <= 1'b0;
      used_reg      <= NUM_PORTS'(`CFG_ZERO);
      removable_reg <= NUM_PORTS'(`CFG_ZERO);
      stat_cmd_reg  <= `STAT_CMD_RST;
      rdata_reg     <= `RDATA_ZERO;
    end else begin
      cfg_state_reg <= cfg_state_next;
      cap_cnt_reg   <= cap_cnt_next;
      gang_mode_reg <= gang_mode_next;
      used_reg      <= used_next;
      removable_reg <= removable_next;
      stat_cmd_reg  <= stat_cmd_next;
      rdata_reg     <= rdata_next;
    end
  end

  // ****************************************************************
  // Power switching
  // ****************************************************************
  logic [NUM_PORTS-1:0] used_eff;
  logic [NUM_PORTS-1:0] req_act;
  logic                 any_oc;
  logic                 any_req;
  logic                 hold;

  assign used_eff = eff_used(used_reg);
  assign req_act  = port_power_req_i & used_eff;
  assign any_oc   = |(oc_det & used_eff);
  assign any_req  = |req_act;
  assign hold     = stat_cmd_reg[`STAT_HOLD_BIT];

  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_latch
    logic lat_oc;
    logic lat_clr;
    assign lat_oc  = gang_mode_reg ? any_oc : (oc_det[i] & used_eff[i]);
    assign lat_clr = gang_mode_reg ? ~any_req : ~req_act[i];
    port_oc_latch u_latch (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst),
      .oc_i      (lat_oc),
      .clr_i     (lat_clr),
      .fault_o   (fault[i])
    );
  end

  logic [NUM_PORTS-1:0] pwr_reg;
  logic [NUM_PORTS-1:0] pwr_next;
  logic [NUM_PORTS-1:0] ss_en_reg;
  logic [NUM_PORTS-1:0] ss_en_next;
  logic [NUM_PORTS-1:0] hs_en_reg;
  logic [NUM_PORTS-1:0] hs_en_next;
  logic [NUM_PORTS-1:0] fixed_reg;
  logic [NUM_PORTS-1:0] fixed_next;
  logic [2:0]           count_reg;
  logic [2:0]           count_next;

  always_comb begin
    pwr_next = '0;
    if (run && !hold) begin
      if (gang_mode_reg) begin
        pwr_next[0] = any_req & ~any_oc & ~(|fault);
      end else begin
        pwr_next = req_act & ~oc_det & ~fault;
      end
    end
    ss_en_next = (run && upstream_ss_i) ? used_eff : '0;
    // high-speed needs upstream SS or HS
    hs_en_next = (run && (upstream_ss_i || upstream_hs_i)) ? used_eff : '0;
    fixed_next = run ? (used_eff & ~removable_reg) : '0;
    count_next = pop_count(used_eff);
  end

  always_ff @(posedge clk_sys_i or posedge rst) begin
    if (rst) begin
      pwr_reg   <= '0;
      ss_en_reg <= '0;
      hs_en_reg <= '0;
      fixed_reg <= '0;
      count_reg <= `PORT_COUNT_RST;
    end else begin
      pwr_reg   <= pwr_next;
      ss_en_reg <= ss_en_next;
      hs_en_reg <= hs_en_next;
      fixed_reg <= fixed_next;
      count_reg <= count_next;
    end
  end

  assign port_power_on_n_o = ~pwr_reg;
  assign ds_ss_en_o        = ss_en_reg;
  assign ds_hs_en_o        = hs_en_reg;
  assign port_fixed_o      = fixed_reg;
  assign port_count_o      = count_reg;
  assign reg_rdata_o       = rdata_reg;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst);

  sequence oc_hit_seq;
    run && !gang_mode_reg && !hold && oc_det[1] && !oc_det[0] && req_act[0] && !fault[0];
  endsequence

  sequence gang_need_seq;
    run && gang_mode_reg && !hold && any_req && !any_oc && !(|fault);
  endsequence

  ss_block_a: assert property (!upstream_ss_i |=> ds_ss_en_o == '0)
    else $error("SuperSpeed enabled without upstream SuperSpeed");
  hs_block_a: assert property (!upstream_ss_i && !upstream_hs_i |=> ds_hs_en_o == '0)
    else $error("High-speed enabled on full-speed upstream");
  both_speeds_a: assert property (run && upstream_ss_i && upstream_hs_i |=>
    (ds_ss_en_o == $past(used_eff)) && (ds_hs_en_o == $past(used_eff)))
    else $error("Concurrent upstream speeds not honoured");
  port_count_a: assert property (##1 (port_count_o >= 3'h1) &&
    (port_count_o == $past(pop_count(used_eff))))
    else $error("Port count out of range");
  fixed_port_a: assert property (run |=> port_fixed_o == $past(used_eff & ~removable_reg))
    else $error("Attached flags wrong");
  per_port_on_a: assert property (run && !gang_mode_reg && !hold &&
    req_act[1] && !oc_det[1] && !fault[1] |=> !port_power_on_n_o[1])
    else $error("Per-port power did not follow request");
  oc_local_a: assert property (oc_hit_seq |=> port_power_on_n_o[1] &&
    !port_power_on_n_o[0])
    else $error("Over-current removed wrong port");
  gang_on_a: assert property (gang_need_seq |=> !port_power_on_n_o[0] ##0
    (port_power_on_n_o[NUM_PORTS-1:1] == '1))
    else $error("Ganged power not applied");
  gang_hold_a: assert property (gang_need_seq ##1 gang_need_seq |=>
    !port_power_on_n_o[0] && $past(!port_power_on_n_o[0]))
    else $error("Ganged power dropped while needed");
  gang_oc_a: assert property (run && gang_mode_reg && any_oc |=>
    port_power_on_n_o == '1 ##1 port_power_on_n_o == '1)
    else $error("Ganged over-current left power on");
  gang_out_a: assert property (gang_mode_reg |=> port_power_on_n_o[NUM_PORTS-1:1] == '1)
    else $error("Ganged mode drove a non-zero port output");
  eeprom_f8_a: assert property (reg_wr_i && reg_src_eeprom_i &&
    reg_addr_i == `REG_STAT_CMD |=> $stable(stat_cmd_reg))
    else $error("EEPROM load altered status register");
  reset_idle_a: assert property (@(posedge clk_sys_i) disable iff (1'b0)
    rst |-> (port_power_on_n_o == '1) && (ds_ss_en_o == '0) && (ds_hs_en_o == '0))
    else $error("Outputs active during reset");
  reset_dflt_a: assert property (@(posedge clk_sys_i) disable iff (1'b0)
    rst |-> (stat_cmd_reg == `STAT_CMD_RST) && (cfg_state_reg == CFG_SETTLE))
    else $error("Register not at default in reset");

endmodule // hub_port_power_control

//--- verification/port_switch_model.sv
// Model of the four external downstream power switches.
// Assumes active-low enables; in ganged mode port 0 enable feeds all.
`timescale 1ns/100ps

module port_switch_model (
  input  wire logic       gang_i,
  input  wire logic [3:0] power_on_n_i,
  input  wire logic [3:0] short_i,
  output logic      [3:0] overcurrent_n_o
);
  logic [3:0] powered;

  // ************
  // Switches
  // ************
  assign powered = gang_i ? {4{~power_on_n_i[0]}} : ~power_on_n_i;
  assign overcurrent_n_o = ~(powered & short_i);
endmodule // port_switch_model

//--- verification/hub_port_power_control_test.sv
// Self-checking bench for the downstream port power block.
// Assumes the switch model on the far side; inputs driven 1 ns after edges.
`timescale 1ns/100ps
`include "hub_power_params.svh"

module hub_port_power_control_test;
  logic       clk, rst_n, gang, wr, src_ee, up_ss, up_hs;
  logic [3:0] used, rem, oc_n, req, pon_n, ss_en, hs_en, fixed, short_cmd;
  logic [7:0] addr, wdata, rdata;
  logic [2:0] count;
  int         n_fail, n_checks;

  hub_port_power_control #(.NUM_PORTS(4)) i_hub_port_power_control (
    .clk_sys_i(clk), .global_reset_n_i(rst_n), .gang_mode_strap_i(gang),
    .strap_port_used_i(used), .strap_removable_i(rem),
    .port_overcurrent_n_i(oc_n), .port_power_req_i(req),
    .upstream_ss_i(up_ss), .upstream_hs_i(up_hs), .reg_wr_i(wr),
    .reg_src_eeprom_i(src_ee), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_rdata_o(rdata), .port_power_on_n_o(pon_n), .ds_ss_en_o(ss_en),
    .ds_hs_en_o(hs_en), .port_fixed_o(fixed), .port_count_o(count));

  port_switch_model i_port_switch_model (
    .gang_i(gang), .power_on_n_i(pon_n), .short_i(short_cmd),
    .overcurrent_n_o(oc_n));

  // ************
  // Helpers
  // ************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk_vec(input logic [3:0] got, input logic [3:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d, input logic ee);
    wr = 1'b1;
    addr = a;
    wdata = d;
    src_ee = ee;
    cyc(1);
    wr = 1'b0;
    cyc(2);
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp);
    addr = a;
    cyc(2);
    chk_byte(rdata & mask, exp, "register read");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ************
  // Scenarios
  // ************
  task automatic do_reset(input logic g);
    gang = g;
    rst_n = 1'b0;
    #1;
    chk_vec(pon_n, 4'hf, "async reset entry");
    cyc(5);
    chk_vec(pon_n, 4'hf, "power during reset");
    chk_vec(ss_en | hs_en | fixed, 4'h0, "flags during reset");
    chk_byte({5'h0, count}, 8'h01, "count during reset");
    rst_n = 1'b1;
    req = 4'h0;
    cyc(12);
  endtask

  task automatic t_config;
    chk_byte({5'h0, count}, 8'h04, "strap count");
    chk_vec(fixed, 4'hf, "strap fixed");
    reg_rd(`REG_PORT_USED, 8'hff, 8'h0f);
    reg_wr(`REG_PORT_USED, 8'h03, 1'b0);
    chk_byte({5'h0, count}, 8'h02, "two ports");
    chk_vec(ss_en, 4'h3, "unused ports off");
    reg_wr(`REG_PORT_USED, 8'h00, 1'b1);
    chk_byte({5'h0, count}, 8'h01, "one port");
    reg_wr(`REG_PORT_USED, 8'h0f, 1'b0);
    reg_wr(`REG_REMOVABLE, 8'h05, 1'b1);
    chk_vec(fixed, 4'ha, "attached ports");
    reg_rd(`REG_REMOVABLE, 8'hff, 8'h05);
    reg_wr(`REG_REMOVABLE, 8'h00, 1'b0);
    reg_rd(8'h09, 8'hff, 8'h00);
  endtask

  task automatic t_speed;
    logic [1:0] up [4];
    logic [3:0] es [4];
    logic [3:0] eh [4];
    up = '{2'b11, 2'b10, 2'b01, 2'b00};
    es = '{4'hf, 4'hf, 4'h0, 4'h0};
    eh = '{4'hf, 4'hf, 4'hf, 4'h0};
    for (int k = 0; k < 4; k++) begin
      {up_ss, up_hs} = up[k];
      cyc(2);
      chk_vec(ss_en, es[k], "superspeed enable");
      chk_vec(hs_en, eh[k], "high-speed enable");
    end
    {up_ss, up_hs} = 2'b11;
  endtask

  task automatic t_per_port;
    req = 4'h5;
    cyc(2);
    chk_vec(pon_n, 4'ha, "per-port follow");
    req = 4'ha;
    cyc(2);
    chk_vec(pon_n, 4'h5, "per-port swap");
    req = 4'hf;
    cyc(2);
    short_cmd = 4'h2;
    cyc(5);
    chk_vec(pon_n, 4'h2, "only faulty port off");
    reg_rd(`REG_STAT_CMD, 8'hf0, 8'h20);
    short_cmd = 4'h0;
    req = 4'hd;
    cyc(2);
    req = 4'hf;
    cyc(2);
    chk_vec(pon_n, 4'h0, "fault cleared");
  endtask

  task automatic t_hold;
    reg_wr(`REG_STAT_CMD, 8'h01, 1'b1);
    chk_vec(pon_n, 4'h0, "loader write ignored");
    reg_rd(`REG_STAT_CMD, 8'h01, 8'h00);
    reg_wr(`REG_STAT_CMD, 8'h01, 1'b0);
    chk_vec(pon_n, 4'hf, "hold forces off");
    reg_wr(`REG_STAT_CMD, 8'h00, 1'b0);
    chk_vec(pon_n, 4'h0, "hold released");
  endtask

  task automatic t_ganged;
    reg_rd(`REG_STAT_CMD, 8'h02, 8'h02);
    req = 4'h4;
    cyc(2);
    chk_vec(pon_n, 4'he, "ganged on by port 2");
    req = 4'h6;
    cyc(2);
    req = 4'h2;
    cyc(2);
    chk_vec(pon_n, 4'he, "ganged stays on");
    req = 4'h0;
    cyc(2);
    chk_vec(pon_n, 4'hf, "ganged all off");
    req = 4'hf;
    cyc(2);
    short_cmd = 4'h8;
    cyc(5);
    chk_vec(pon_n, 4'hf, "ganged fault all off");
    short_cmd = 4'h0;
    req = 4'h0;
    cyc(2);
    req = 4'h1;
    cyc(2);
    chk_vec(pon_n, 4'he, "ganged recovers");
  endtask

  // ************
  // Main
  // ************
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial begin
    #100000;
    n_fail++;
    test_done();
  end

  initial begin
    {rst_n, gang, wr, src_ee, up_ss, up_hs} = 6'b000011;
    used = 4'hf;
    rem = 4'h0;
    req = 4'h0;
    short_cmd = 4'h0;
    addr = 8'h00;
    wdata = 8'h00;
    n_fail = 0;
    n_checks = 0;
    cyc(1);
    do_reset(1'b0);
    t_config();
    t_speed();
    t_per_port();
    t_hold();
    do_reset(1'b1);
    t_ganged();
    test_done();
  end
endmodule // hub_port_power_control_test
